// ---- seecmd_pkg.sv ----
package seecmd_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OP_SEC_READ = 8'h83;
    localparam logic [7:0] OP_SEC_WRITE = 8'h82;
    localparam int BUSY_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam int BP_LO_BIT = 2;
    localparam int BP_HI_BIT = 3;
    localparam int SPD_BIT = 7;
    localparam logic [7:0] STATUS_WRITABLE_MASK = 8'h8C;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WRITE_CYCLE_TIME_NS = 5000000;
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int PAGE_BYTES = 128;
    localparam logic [15:0] PROT_QUARTER_BASE = 16'hC000;
    localparam logic [15:0] PROT_HALF_BASE = 16'h8000;
    localparam int ADDR_PHASE_END = 24;
    localparam int LOCK_BIT_IN_DATA = 1;

    typedef enum logic [1:0] {SEE_SP_ADDR, SEE_SP_LOCK, SEE_SP_UID} seecmd_sel_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } seecmd_wr_type;
endpackage

// ---- seecmd_fifo.sv ----
`timescale 1ns/100ps
module seecmd_fifo
    import seecmd_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("FIFO depth must be a power of two");
        end
    end
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } seecmd_fptr_type;
    seecmd_fptr_type s_r, s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty;
    assign full = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
    assign empty = s_r.wp == s_r.rp;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[s_r.rp[AW-1:0]];
    always_comb begin
        s_nxt = s_r;
        if (in_valid && !full) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (in_valid && !full) begin
            mem[s_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// ---- seecmd_engine.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// (RL1) Write-enable opcode framed by chip select sets the write enable latch.
// (RL2) Host must send write-enable before every array or status write.
// (RL3) Write-disable opcode framed by chip select clears the write enable latch.
// (RL4) Latch clears at reset and when status or array write completes.
// (RL5) Status read drives eight status bits on falling edges, MSB first.
// (RL6) Status read works anytime, even busy, repeating while select stays low.
// (RL7) Status write changes only protect-disable and the two block-protect bits.
// (RL8) Status write executes only if select rises right after eighth data bit.
// (RL9) Accepted status write runs timed busy cycle, then clears busy and latch.
// (RL10) Array read takes opcode and 16-bit address, then streams byte MSB first.
// (RL11) Array read advances address after each byte until select rises.
// (RL12) Array read during a write cycle is ignored.
// (RL13) Array write: opcode, address, one to 128 bytes, select low, latch set.
// (RL14) Write addressing wraps in 128-byte page; unsent bytes stay unchanged.
// (RL15) Array write discarded unless select rises on a byte boundary.
// (RL16) Accepted array write runs timed busy cycle, then clears busy and latch.
// (RL17) Array write to a protected page is not executed.
// (RL18) Sector read with bits 10:9 zero; low seven bits start, wrap at end.
// (RL19) Sector read refused during a write cycle.
// (RL20) Sector write with bits 10:9 zero, one to 128 bytes, needs latch.
// (RL21) Sector write discarded when both protect bits set or sector locked.
// (RL22) Sector opcodes with bits 10:9 equal 10 select lock functions.
// (RL23) Sector read with bit 9 set reads unique ID from bits 3:0.
// (RL24) While busy, every instruction except status read is ignored.
// (RL25) Protect 00 none, 01 upper quarter, 10 upper half, 11 all.
// (RL26) Protect-disable set with protect pin low refuses status writes.
// (RL27) Instruction starts at select fall; input sampled rising edges, MSB first.
// (RL28) Sector write addressing wraps within the 128-byte sector.
// (RL29) Continuous array read rolls over from top address to zero.
module seecmd_engine
    import seecmd_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES,
    parameter int ARRAY_BYTES = 65536,
    parameter int FIFO_DEPTH = 8,
    parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_0011_2233_4455_6677
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_IN,
    input wire logic WRITE_PROTECT_N,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_EN_N,
    output logic [7:0] STATUS,
    output logic SECTOR_LOCKED
);
    // UNIQUE_ID default is arbitrary
    initial begin
        if (ARRAY_BYTES != 65536 || WRITE_CYCLES < 1) begin
            $error("Unsupported engine parameters");
        end
    end

    // ************
    // Types
    // ************
    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_READ, ST_WRDATA, ST_IGNORE, ST_SINGLE
    } seecmd_state_type;
    typedef enum logic [1:0] {WS_IDLE, WS_DRAIN, WS_TIMED} seecmd_wstate_type;
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [1:0] si_s;
        logic [1:0] wp_s;
        seecmd_state_type st;
        logic [7:0] opcode;
        logic [4:0] bitcnt;
        logic [15:0] addr;
        logic [7:0] shin;
        logic [7:0] shout;
        logic [2:0] outcnt;
        logic out_en;
        logic dout;
        logic [7:0] status;
        logic locked;
        logic wr_pending;
        logic wr_sector;
        logic wr_to_status;
        logic [7:0] wr_stat_val;
        logic [15:0] wr_base;
        logic wr_bad;
        logic [7:0] nbytes;
        logic [127:0] pagemask;
        logic do_lock;
        seecmd_wstate_type ws;
        logic [31:0] timer;
    } seecmd_state_all_type;

    seecmd_state_all_type s_r, s_nxt;
    logic [7:0] mem [ARRAY_BYTES];
    logic [7:0] sector [PAGE_BYTES];
    logic [7:0] pagebuf [PAGE_BYTES];
    logic buf_we;
    logic [6:0] buf_idx;
    logic [7:0] buf_data;

    // ************
    // Byte FIFO between shifter and programming
    // ************
    seecmd_wr_type fifo_in, fifo_out;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    seecmd_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .reset_n(RESET_N),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    logic cs_low, cs_fall, cs_rise, sck_rise, sck_fall, busy, sel_ok;
    logic [7:0] rbyte;
    logic [1:0] bp;
    logic prot_page;
    assign cs_low = !s_r.cs_s[1];
    assign cs_fall = s_r.cs_s[2] && !s_r.cs_s[1];
    assign cs_rise = !s_r.cs_s[2] && s_r.cs_s[1];
    assign sck_rise = !s_r.sck_s[2] && s_r.sck_s[1];
    assign sck_fall = s_r.sck_s[2] && !s_r.sck_s[1];
    assign busy = s_r.status[BUSY_BIT];
    assign bp = {s_r.status[BP_HI_BIT], s_r.status[BP_LO_BIT]};
    assign fifo_out_ready = 1'b1;
    assign sel_ok = s_r.addr[10:9] == 2'b00;

    // ************
    // Protection decode
    // ************
    always_comb begin
        case (bp) // [RL25]
            2'b00: prot_page = 1'b0;
            2'b01: prot_page = s_r.addr >= PROT_QUARTER_BASE;
            2'b10: prot_page = s_r.addr >= PROT_HALF_BASE;
            default: prot_page = 1'b1;
        endcase
    end

    // Byte fetched for output at the current address
    always_comb begin
        rbyte = 8'h00;
        if (s_r.opcode == OP_STATUS_READ) begin
            rbyte = s_r.status;
        end else if (s_r.opcode == OP_ARRAY_READ) begin
            rbyte = mem[s_r.addr];
        end else if (s_r.addr[9]) begin
            rbyte = UNIQUE_ID[8'(127 - 8 * s_r.addr[3:0]) -: 8]; // [RL23]
        end else if (s_r.addr[10]) begin
            rbyte = {6'b0, s_r.locked, 1'b0}; // [RL22]
        end else begin
            rbyte = sector[s_r.addr[6:0]]; // [RL18]
        end
    end

    assign fifo_in.addr = s_r.addr;
    assign fifo_in.data = {s_r.shin[6:0], s_r.si_s[1]};

    always_comb begin
        s_nxt = s_r;
        fifo_in_valid = 1'b0;
        buf_we = 1'b0;
        buf_idx = fifo_out.addr[6:0];
        buf_data = fifo_out.data;
        s_nxt.cs_s = {s_r.cs_s[1:0], CHIP_SELECT_N};
        s_nxt.sck_s = {s_r.sck_s[1:0], SERIAL_CLK};
        s_nxt.si_s = {s_r.si_s[0], SERIAL_IN};
        s_nxt.wp_s = {s_r.wp_s[0], WRITE_PROTECT_N};

        if (cs_fall) begin // [RL27]
            s_nxt.st = ST_OPCODE;
            s_nxt.bitcnt = '0;
            s_nxt.out_en = 1'b0;
        end else if (cs_low && sck_rise) begin
            s_nxt.shin = {s_r.shin[6:0], s_r.si_s[1]}; // [RL27]
            s_nxt.bitcnt = s_r.bitcnt + 5'd1;
            case (s_r.st)
                ST_OPCODE: begin
                    if (s_r.bitcnt == 5'd7) begin
                        s_nxt.opcode = {s_r.shin[6:0], s_r.si_s[1]};
                        s_nxt.bitcnt = '0;
                        s_nxt.st = ST_IGNORE;
                        if (s_nxt.opcode == OP_STATUS_READ) begin // [RL6]
                            s_nxt.st = ST_READ;
                            s_nxt.shout = s_r.status;
                            s_nxt.outcnt = '0;
                        end else if (busy) begin
                            s_nxt.st = ST_IGNORE; // [RL24] [RL12] [RL19]
                        end else if (s_nxt.opcode == OP_WRITE_ENABLE
                                || s_nxt.opcode == OP_WRITE_DISABLE) begin
                            s_nxt.st = ST_SINGLE; // Any further bit spoils it
                        end else if (s_nxt.opcode == OP_STATUS_WRITE) begin
                            s_nxt.st = ST_WRDATA;
                            s_nxt.nbytes = '0;
                        end else if (s_nxt.opcode == OP_ARRAY_READ
                                || s_nxt.opcode == OP_ARRAY_WRITE
                                || s_nxt.opcode == OP_SEC_READ
                                || s_nxt.opcode == OP_SEC_WRITE) begin
                            s_nxt.st = ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    s_nxt.addr = {s_r.addr[14:0], s_r.si_s[1]};
                    if (s_r.bitcnt == 5'd15) begin
                        s_nxt.bitcnt = '0;
                        s_nxt.nbytes = '0;
                        if (s_r.opcode[1:0] == 2'b11) begin
                            s_nxt.st = ST_READ; // [RL10]
                            s_nxt.outcnt = '0;
                        end else begin
                            s_nxt.st = ST_WRDATA;
                            s_nxt.wr_base = s_nxt.addr;
                        end
                    end
                end
                ST_WRDATA: begin
                    if (s_r.bitcnt[2:0] == 3'd7) begin
                        s_nxt.bitcnt = '0;
                        if (s_r.nbytes != 8'hFF) begin
                            s_nxt.nbytes = s_r.nbytes + 8'd1;
                        end
                        if (s_r.opcode == OP_STATUS_WRITE) begin
                            s_nxt.wr_stat_val = {s_r.shin[6:0], s_r.si_s[1]};
                        end else if (s_r.opcode == OP_SEC_WRITE && s_r.addr[10]) begin
                            s_nxt.do_lock = s_r.shin[0]; // Bit 1 of the byte
                        end else begin
                            fifo_in_valid = 1'b1;
                            if (!fifo_in_ready) begin
                                s_nxt.wr_bad = 1'b1; // Overrun spoils the page
                            end
                            s_nxt.addr = {s_r.addr[15:7], s_r.addr[6:0] + 7'd1}; // [RL14] [RL28]
                        end
                    end
                end
                ST_SINGLE: begin
                    s_nxt.st = ST_IGNORE;
                end
                default: begin
                end
            endcase
        end

        // Output shifter on falling serial clock edges
        if (cs_low && sck_fall && s_r.st == ST_READ) begin
            s_nxt.out_en = 1'b1;
            s_nxt.dout = s_r.shout[7]; // [RL5] [RL10]
            s_nxt.shout = {s_r.shout[6:0], 1'b0};
            s_nxt.outcnt = s_r.outcnt + 3'd1;
            if (s_r.outcnt == 3'd0) begin
                s_nxt.dout = rbyte[7];
                s_nxt.shout = {rbyte[6:0], 1'b0};
            end
            if (s_r.outcnt == 3'd7) begin
                if (s_r.opcode == OP_ARRAY_READ) begin
                    s_nxt.addr = s_r.addr + 16'd1; // [RL11] [RL29]
                end else if (s_r.opcode == OP_SEC_READ && s_r.addr[9]) begin
                    s_nxt.addr = {s_r.addr[15:4], s_r.addr[3:0] + 4'd1};
                end else if (s_r.opcode == OP_SEC_READ && !s_r.addr[10]) begin
                    s_nxt.addr = {s_r.addr[15:7], s_r.addr[6:0] + 7'd1}; // [RL18]
                end
            end
        end

        // ************
        // End of frame
        // ************
        if (cs_rise) begin
            s_nxt.out_en = 1'b0;
            s_nxt.st = ST_IGNORE;
            if (s_r.st == ST_SINGLE && !busy) begin
                if (s_r.opcode == OP_WRITE_ENABLE) begin
                    s_nxt.status[WEL_BIT] = 1'b1; // [RL1]
                end else if (s_r.opcode == OP_WRITE_DISABLE) begin
                    s_nxt.status[WEL_BIT] = 1'b0; // [RL3]
                end
            end
            if (s_r.st == ST_WRDATA && s_r.bitcnt == 5'd0 && s_r.nbytes != 8'd0
                    && s_r.status[WEL_BIT]) begin // [RL15]
                if (s_r.opcode == OP_STATUS_WRITE) begin
                    if (s_r.nbytes == 8'd1
                            && !(s_r.status[SPD_BIT] && !s_r.wp_s[1])) begin // [RL8] [RL26]
                        s_nxt.wr_pending = 1'b1;
                        s_nxt.wr_to_status = 1'b1;
                    end
                end else if (s_r.opcode == OP_ARRAY_WRITE) begin
                    if (!prot_page) begin // [RL17] [RL13]
                        s_nxt.wr_pending = 1'b1;
                        s_nxt.wr_to_status = 1'b0;
                        s_nxt.wr_sector = 1'b0;
                    end
                end else if (bp != 2'b11 && !s_r.locked) begin // [RL21]
                    if (s_r.addr[10:9] == 2'b10 && s_r.nbytes == 8'd1 && s_r.do_lock) begin
                        s_nxt.locked = 1'b1; // [RL22]
                        s_nxt.wr_pending = 1'b1;
                        s_nxt.wr_to_status = 1'b1;
                        s_nxt.wr_stat_val = s_r.status;
                    end else if (sel_ok) begin // [RL20]
                        s_nxt.wr_pending = 1'b1;
                        s_nxt.wr_to_status = 1'b0;
                        s_nxt.wr_sector = 1'b1;
                    end
                end
            end
        end

        // ************
        // Page buffering and self-timed cycle
        // ************
        if (fifo_out_valid) begin
            buf_we = 1'b1;
            s_nxt.pagemask[fifo_out.addr[6:0]] = 1'b1; // [RL14]
        end
        case (s_r.ws)
            WS_IDLE: begin
                if (s_r.wr_pending) begin
                    s_nxt.wr_pending = 1'b0;
                    s_nxt.status[BUSY_BIT] = 1'b1; // [RL9] [RL16]
                    s_nxt.ws = WS_DRAIN;
                end else if (!fifo_out_valid && cs_fall) begin
                    s_nxt.pagemask = '0;
                    s_nxt.wr_bad = 1'b0;
                end
            end
            WS_DRAIN: begin
                if (!fifo_out_valid) begin
                    s_nxt.ws = WS_TIMED;
                    s_nxt.timer = 32'(WRITE_CYCLES - 1);
                    if (s_r.wr_to_status) begin
                        s_nxt.status = (s_r.status & ~STATUS_WRITABLE_MASK)
                            | (s_r.wr_stat_val & STATUS_WRITABLE_MASK); // [RL7]
                    end
                end
            end
            default: begin
                s_nxt.timer = s_r.timer - 32'd1;
                if (s_r.timer == 32'd0) begin
                    s_nxt.ws = WS_IDLE;
                    s_nxt.status[BUSY_BIT] = 1'b0; // [RL9] [RL16]
                    s_nxt.status[WEL_BIT] = 1'b0; // [RL4]
                    s_nxt.pagemask = '0;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s_r <= '0;
            s_r.cs_s <= 3'b111;
            s_r.st <= ST_IGNORE;
            s_r.status <= STATUS_RESET; // [RL4]
        end else begin
            s_r <= s_nxt;
        end
    end

    // Commit when the FIFO has drained, before the timed cycle, keeps partial pages intact
    always_ff @(posedge CLK) begin
        if (buf_we) begin
            pagebuf[buf_idx] <= buf_data;
        end
        if (s_r.ws == WS_DRAIN && !fifo_out_valid && !s_r.wr_to_status && !s_r.wr_bad) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (s_r.pagemask[i]) begin
                    if (s_r.wr_sector) begin
                        sector[i] <= pagebuf[i];
                    end else begin
                        mem[{s_r.wr_base[15:7], 7'(i)}] <= pagebuf[i]; // [RL14]
                    end
                end
            end
        end
    end

    assign SERIAL_OUT = s_r.dout;
    assign SERIAL_OUT_EN_N = !s_r.out_en;
    assign STATUS = s_r.status;
    assign SECTOR_LOCKED = s_r.locked;
endmodule

// ---- seecmd_engine_asserts.sv ----
`timescale 1ns/100ps
module seecmd_engine_asserts
    import seecmd_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_IN,
    input wire logic WRITE_PROTECT_N,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_EN_N,
    input wire logic [7:0] STATUS,
    input wire logic SECTOR_LOCKED
);
    // ****************
    // Busy length counter
    // ****************
    int unsigned busy_cnt_r;
    always_ff @(posedge CLK) begin
        busy_cnt_r <= (RESET_N && STATUS[BUSY_BIT]) ? busy_cnt_r + 1 : 0;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence busy_start_s;
        $rose(STATUS[BUSY_BIT]);
    endsequence
    sequence busy_end_s;
        $fell(STATUS[BUSY_BIT]);
    endsequence
    AST_RESET_VALUES: assert property (disable iff (1'b0) !RESET_N |=>
        STATUS == STATUS_RESET && !SECTOR_LOCKED && SERIAL_OUT_EN_N)
        else $error("outputs not at reset values");
    AST_BUSY_NEEDS_LATCH: assert property (busy_start_s |-> $past(STATUS[WEL_BIT]))
        else $error("write cycle started without latch");
    AST_BUSY_AFTER_DESELECT: assert property (busy_start_s |-> $past(CHIP_SELECT_N, 2))
        else $error("write cycle started inside a frame");
    AST_BUSY_LENGTH: assert property (busy_end_s |-> busy_cnt_r >= WRITE_CYCLES
        && busy_cnt_r <= WRITE_CYCLES + 40)
        else $error("write cycle length wrong");
    AST_LATCH_CLEARS_AT_END: assert property (busy_end_s |-> ##[0:2] !STATUS[WEL_BIT])
        else $error("latch not cleared after write cycle");
    AST_LATCH_SET_IDLE: assert property ($rose(STATUS[WEL_BIT]) |->
        !STATUS[BUSY_BIT] && $past(CHIP_SELECT_N, 2))
        else $error("latch set while busy or inside frame");
    AST_READONLY_BITS: assert property (STATUS[6:4] == 3'h0)
        else $error("read-only status bits changed");
    AST_NV_BITS_AT_CYCLE: assert property ($changed(STATUS & STATUS_WRITABLE_MASK) |->
        STATUS[BUSY_BIT] || $past(STATUS[BUSY_BIT]))
        else $error("protect bits changed outside write cycle");
    AST_LOCK_STICKY: assert property (!$fell(SECTOR_LOCKED))
        else $error("sector lock dropped");
    AST_DRIVE_ONLY_SELECTED: assert property (CHIP_SELECT_N[*6] |-> SERIAL_OUT_EN_N)
        else $error("data out driven while deselected");
    AST_OUT_STEADY_CLK_HIGH: assert property (SERIAL_CLK && $past(SERIAL_CLK) |->
        $stable(SERIAL_OUT))
        else $error("data out moved while serial clock high");
    COV_BUSY: cover property (busy_start_s);
endmodule
bind seecmd_engine seecmd_engine_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_seecmd_engine_asserts (
    .CLK(CLK), .RESET_N(RESET_N), .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_CLK(SERIAL_CLK),
    .SERIAL_IN(SERIAL_IN), .WRITE_PROTECT_N(WRITE_PROTECT_N), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OUT_EN_N(SERIAL_OUT_EN_N), .STATUS(STATUS), .SECTOR_LOCKED(SECTOR_LOCKED));

// ---- seecmd_host.sv ----
`timescale 1ns/100ps
module seecmd_host (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    // ****************
    // Mode 0 bus master, serial clock 160 ns
    // ****************
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic half();
        repeat (16) @(posedge clk);
    endtask
    task automatic frame(input logic [7:0] tx[$], input int n_rx, input int extra,
                         output logic [7:0] rx[$]);
        logic [7:0] b;
        logic [7:0] sh;
        rx = {};
        cs_n <= 1'b0;
        half();
        for (int i = 0; i < (tx.size() + n_rx) * 8 + extra; i++) begin
            b = (i / 8 < tx.size()) ? tx[i / 8] : 8'hA5;
            mosi <= b[7 - i % 8];
            half();
            sclk <= 1'b1;
            sh = {sh[6:0], miso};
            if (i % 8 == 7 && i / 8 >= tx.size()) rx.push_back(sh);
            half();
            sclk <= 1'b0;
        end
        half();
        cs_n <= 1'b1;
        // Released line shows the inverse, not the last bit
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- seecmd_engine_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module seecmd_engine_test
    import seecmd_pkg::*;
;
    localparam int WCYC = 1300;
    localparam logic [127:0] UID = 128'hC3A5_1E0F_7788_9900_AABB_CCDD_EEFF_1234; // Arbitrary
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    wire cs_n, sclk, mosi;
    logic so, so_en_n, locked;
    logic [7:0] status;
    logic [7:0] rx[$];
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    seecmd_engine #(.WRITE_CYCLES(WCYC), .UNIQUE_ID(UID)) u_seecmd_engine (.CLK(clk),
        .RESET_N(reset_n), .CHIP_SELECT_N(cs_n), .SERIAL_CLK(sclk), .SERIAL_IN(mosi),
        .WRITE_PROTECT_N(wp_n), .SERIAL_OUT(so), .SERIAL_OUT_EN_N(so_en_n),
        .STATUS(status), .SECTOR_LOCKED(locked));
    seecmd_host u_seecmd_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .miso(so_en_n ? 1'b1 : so));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            end_sim();
        end
    end
    // ****************
    // Shared helpers
    // ****************
    task automatic send(input logic [7:0] tx[$], input int n_rx = 0, input int extra = 0);
        u_seecmd_host.frame(tx, n_rx, extra, rx);
    endtask
    task automatic write_enable_cmd();
        send({OP_WRITE_ENABLE});
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (status[BUSY_BIT] !== 1'b0 && n < 1600) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy end", 1'b0, status[BUSY_BIT])
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_latch();
        `CHK("reset status", 8'h00, status)
        write_enable_cmd();
        `CHK("latch set", 1'b1, status[WEL_BIT])
        send({OP_WRITE_DISABLE});
        `CHK("latch clear", 1'b0, status[WEL_BIT])
        send({OP_ARRAY_WRITE, 8'h00, 8'h10, 8'h99});
        `CHK("no latch write", 1'b0, status[BUSY_BIT])
        $display("test latch done");
    endtask
    task automatic t_page();
        write_enable_cmd();
        send({OP_ARRAY_WRITE, 8'h00, 8'h10, 8'h11, 8'h22, 8'h33});
        `CHK("write busy", 1'b1, status[BUSY_BIT])
        send({OP_STATUS_READ}, 2);
        `CHK("status busy", 8'h03, rx[0])
        `CHK("status again", 8'h03, rx[1])
        send({OP_WRITE_ENABLE});
        wait_idle();
        `CHK("status after", 8'h00, status)
        send({OP_ARRAY_READ, 8'h00, 8'h10}, 3);
        `CHK("rd0", 8'h11, rx[0])
        `CHK("rd2", 8'h33, rx[2])
        write_enable_cmd();
        send({OP_ARRAY_WRITE, 8'h00, 8'h7F, 8'hA1, 8'hB2});
        wait_idle();
        send({OP_ARRAY_READ, 8'h00, 8'h00}, 1);
        `CHK("wrap byte", 8'hB2, rx[0])
        send({OP_ARRAY_READ, 8'h00, 8'h10}, 1);
        `CHK("unsent kept", 8'h11, rx[0])
        send({OP_ARRAY_READ, 8'hFF, 8'hFF}, 2);
        `CHK("rollover", 8'hB2, rx[1])
        write_enable_cmd();
        send({OP_ARRAY_WRITE, 8'h00, 8'h10, 8'h44}, 0, 4);
        `CHK("partial byte", 1'b0, status[BUSY_BIT])
        $display("test page done");
    endtask
    task automatic t_protect();
        send({OP_STATUS_WRITE, 8'hFF});
        `CHK("status_write_cmd busy", 1'b1, status[BUSY_BIT])
        wait_idle();
        `CHK("status_write_cmd bits", 8'h8C, status)
        write_enable_cmd();
        send({OP_ARRAY_WRITE, 8'h00, 8'h00, 8'h77});
        `CHK("all protected", 1'b0, status[BUSY_BIT])
        send({OP_SEC_WRITE, 8'h00, 8'h00, 8'h77});
        `CHK("sector bp11", 1'b0, status[BUSY_BIT])
        wp_n <= 1'b0;
        send({OP_STATUS_WRITE, 8'h00});
        `CHK("hw protect", 8'h8E, status)
        wp_n <= 1'b1;
        send({OP_STATUS_WRITE, 8'h00, 8'h00});
        `CHK("status_write_cmd long", 1'b0, status[BUSY_BIT])
        send({OP_STATUS_WRITE, 8'h04});
        wait_idle();
        `CHK("bp quarter", 8'h04, status)
        write_enable_cmd();
        send({OP_ARRAY_WRITE, 8'hC0, 8'h00, 8'h5A});
        `CHK("quarter hit", 1'b0, status[BUSY_BIT])
        send({OP_ARRAY_WRITE, 8'h80, 8'h00, 8'h5A});
        `CHK("quarter miss", 1'b1, status[BUSY_BIT])
        send({OP_ARRAY_READ, 8'h00, 8'h10}, 1);
        `CHK("read while busy", 8'hFF, rx[0])
        wait_idle();
        write_enable_cmd();
        send({OP_STATUS_WRITE, 8'h00});
        wait_idle();
        $display("test protect done");
    endtask
    task automatic t_sector();
        write_enable_cmd();
        send({OP_SEC_WRITE, 8'h00, 8'h7F, 8'hC1, 8'hD2});
        wait_idle();
        send({OP_SEC_READ, 8'h00, 8'h7F}, 2);
        `CHK("sector 7f", 8'hC1, rx[0])
        `CHK("sector wrap", 8'hD2, rx[1])
        send({OP_SEC_READ, 8'h02, 8'h00}, 1);
        `CHK("uid byte", UID[127:120], rx[0])
        write_enable_cmd();
        send({OP_SEC_WRITE, 8'h04, 8'h00, 8'h02});
        send({OP_SEC_READ, 8'h00, 8'h7F}, 1);
        `CHK("sector rd busy", 8'hFF, rx[0])
        wait_idle();
        `CHK("locked", 1'b1, locked)
        send({OP_SEC_READ, 8'h04, 8'h00}, 1);
        `CHK("lock status", 1'b1, rx[0][LOCK_BIT_IN_DATA])
        write_enable_cmd();
        send({OP_SEC_WRITE, 8'h00, 8'h00, 8'h55});
        `CHK("locked write", 1'b0, status[BUSY_BIT])
        $display("test sector done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_latch();
        t_page();
        write_enable_cmd();
        t_protect();
        t_sector();
        end_sim();
    end
endmodule
